// ===== hw/amsf_pkg.sv
// amsf_pkg: shared constants and types for the alignment, machine-check and simd fault unit
package amsf_pkg;

  // exception vectors
  localparam logic [7:0] VEC_ALIGN = 8'h11;
  localparam logic [7:0] VEC_MCHECK = 8'h12;
  localparam logic [7:0] VEC_SIMD = 8'h13;
  localparam logic [7:0] VEC_GEN_PROT = 8'h0d;
  localparam logic [7:0] VEC_BAD_OPCODE = 8'h06;

  localparam logic [1:0] USER_PRIV = 2'h3;
  localparam logic [31:0] ERR_CODE_ZERO = 32'h0000_0000;

  // operand size classes seen by the alignment check
  typedef enum logic [2:0] {
    AMSF_SZ_BYTE = 3'h0,
    AMSF_SZ_WORD = 3'h1,
    AMSF_SZ_DWORD = 3'h2,
    AMSF_SZ_QWORD = 3'h3,
    AMSF_SZ_DQWORD = 3'h4,
    AMSF_SZ_FXSTATE = 3'h5
  } amsf_size_t;

  // low address bits that must be zero for each natural boundary
  localparam logic [3:0] AMASK_WORD = 4'h1;
  localparam logic [3:0] AMASK_DWORD = 4'h3;
  localparam logic [3:0] AMASK_QWORD = 4'h7;
  localparam logic [3:0] AMASK_DQWORD = 4'hf;

  // per-element condition inputs
  localparam int COND_W = 8;
  localparam int COND_SIGNALING_NAN = 0;
  localparam int COND_QUIET_NAN = 1;
  localparam int COND_INV = 2;
  localparam int COND_DIVZ = 3;
  localparam int COND_DENORM = 4;
  localparam int COND_OVF = 5;
  localparam int COND_UNF = 6;
  localparam int COND_INEX = 7;

  // flag and mask bit positions of the simd control/status state
  localparam int FLG_W = 6;
  localparam int FLG_INV = 0;
  localparam int FLG_DIVZ = 1;
  localparam int FLG_DENORM = 2;
  localparam int FLG_OVF = 3;
  localparam int FLG_UNF = 4;
  localparam int FLG_INEX = 5;
  localparam logic [5:0] SIMD_MASK_RST = 6'h3f;
  localparam logic [5:0] SIMD_FLAG_RST = 6'h00;

  // machine-check control state
  typedef enum logic [2:0] {
    AMSF_MC_RUN = 3'b001,
    AMSF_MC_LATCHED = 3'b010,
    AMSF_MC_SHUT = 3'b100
  } amsf_mc_state_t;

endpackage : amsf_pkg

// ===== hw/amsf_elem_prio.sv
// amsf_elem_prio: priority resolution of numeric conditions for one packed element
module amsf_elem_prio
  import amsf_pkg::*;
(
  // conditions found in this element, and current masks
  input wire logic [COND_W-1:0] i_cond,
  input wire logic [FLG_W-1:0] i_mask,
  // reported flags and whether any of them is unmasked
  output logic [FLG_W-1:0] o_flags,
  output logic o_unmasked,
  output logic o_quiet_nan_res
);

  logic stop;

  // walk from highest to lowest priority; a masked report lets lower ones through
  always_comb begin
    o_flags = '0;
    o_quiet_nan_res = 1'b0;
    stop = 1'b0;
    if (i_cond[COND_SIGNALING_NAN]) begin // RULE22
      o_flags[FLG_INV] = 1'b1;
      stop = ~i_mask[FLG_INV];
    end
    if (!stop && i_cond[COND_QUIET_NAN]) begin // RULE23
      o_quiet_nan_res = 1'b1;
      stop = 1'b1;
    end
    if (!stop && i_cond[COND_INV]) begin
      o_flags[FLG_INV] = 1'b1;
      stop = ~i_mask[FLG_INV];
    end else if (!stop && i_cond[COND_DIVZ]) begin
      o_flags[FLG_DIVZ] = 1'b1;
      stop = ~i_mask[FLG_DIVZ];
    end
    if (!stop && i_cond[COND_DENORM]) begin // RULE24
      o_flags[FLG_DENORM] = 1'b1;
      stop = ~i_mask[FLG_DENORM];
    end
    // an unmasked pre-computation condition means the arithmetic never ran
    if (!stop && i_cond[COND_OVF]) begin // RULE15
      o_flags[FLG_OVF] = 1'b1;
      stop = ~i_mask[FLG_OVF];
    end else if (!stop && i_cond[COND_UNF]) begin
      o_flags[FLG_UNF] = 1'b1;
      stop = ~i_mask[FLG_UNF];
    end
    if (!stop && i_cond[COND_INEX]) begin
      o_flags[FLG_INEX] = 1'b1;
    end
  end

  assign o_unmasked = |(o_flags & ~i_mask); // RULE17

endmodule : amsf_elem_prio

// ===== hw/amsf_fault_unit.sv
// amsf_fault_unit: alignment-check, machine-check and simd numeric fault logic
//
// Operation
// RULE1 - vectors 17, 18, 19 for the three faults
// RULE2 - checking needs mask bit, flag, privilege 3
// RULE3 - natural boundaries 2, 4, 8 bytes
// RULE4 - alignment fault only at privilege 3
// RULE5 - implicit privilege 0 references never fault
// RULE6 - misaligned state image: alignment or protection fault
// RULE7 - unaligned moves: no protection fault, alignment checked
// RULE8 - alignment error code zero, pointer names instruction
// RULE9 - faulting instruction has no effect
// RULE10 - bus error pin loads state, raises machine check
// RULE11 - machine check is abort, no error code
// RULE12 - machine check disabled means shutdown
// RULE13 - pointer valid bit when pointer tied to error
// RULE14 - six sticky flags and six masks
// RULE15 - pre-computation conditions before post-computation ones
// RULE16 - masked condition: flag, default result, continue
// RULE17 - unmasked with os support raises simd fault
// RULE18 - unmasked without os support raises bad opcode
// RULE19 - simd faults precise, never left pending
// RULE20 - clearing a mask never raises a fault
// RULE21 - every element evaluated and reported separately
// RULE22 - one condition per element by priority
// RULE23 - quiet nan outranks lower conditions
// RULE24 - masked higher condition lets lower one report
module amsf_fault_unit
  import amsf_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int IP_W = 32,
  parameter int SEG_W = 16,
  parameter int ELEMS = 4,
  parameter int MC_INFO_W = 32,
  parameter bit FXS_USE_ALIGN = 1'b1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // privilege and control state
  input wire logic i_align_mask_bit,
  input wire logic i_proc_flags_ac,
  input wire logic [1:0] i_current_priv_level,
  input wire logic i_mcheck_enable,
  input wire logic i_os_simd_fault_support,
  // faulting instruction identity
  input wire logic [IP_W-1:0] i_instr_pointer,
  input wire logic [SEG_W-1:0] i_code_seg,
  // data reference from the pipeline
  input wire logic i_mem_req,
  input wire logic [ADDR_W-1:0] i_mem_addr,
  input wire amsf_size_t i_mem_size,
  input wire logic i_mem_implicit,
  input wire logic i_mem_unaligned_ok,
  output logic o_mem_inhibit,
  // machine-check sources
  input wire logic i_bus_init_err_n,
  input wire logic i_mcheck_err_n,
  input wire logic i_mcheck_pin_en,
  input wire logic i_int_mcheck,
  input wire logic [MC_INFO_W-1:0] i_mc_info,
  input wire logic i_mc_ptr_assoc,
  input wire logic i_mc_status_clr,
  // machine-check state
  output logic o_mc_valid,
  output logic [MC_INFO_W-1:0] o_mc_info,
  output logic o_saved_ptr_valid,
  output logic [2:0] o_mc_source,
  output logic o_shutdown,
  // simd numeric request and control/status state
  input wire logic i_simd_req,
  input wire logic i_simd_two_elems,
  input wire logic [ELEMS*COND_W-1:0] i_simd_cond,
  input wire logic i_simd_mask_wr,
  input wire logic [FLG_W-1:0] i_simd_mask_data,
  input wire logic [FLG_W-1:0] i_simd_flag_clr,
  output logic [FLG_W-1:0] o_simd_flags,
  output logic [FLG_W-1:0] o_simd_masks,
  output logic o_simd_default_res,
  output logic [ELEMS-1:0] o_simd_quiet_nan_res,
  // fault delivery
  output logic o_fault,
  output logic [7:0] o_fault_vec,
  output logic o_fault_abort,
  output logic o_fault_err_valid,
  output logic [31:0] o_fault_err_code,
  output logic [IP_W-1:0] o_fault_ip,
  output logic [SEG_W-1:0] o_fault_cs
);

  localparam int HALF = ELEMS / 2;

  amsf_mc_state_t mc_state;
  amsf_mc_state_t next_mc_state;
  logic check_on;
  logic align_hit;
  logic gprot_hit;
  logic [3:0] low_addr;
  logic [1:0] pin_sync1;
  logic [1:0] pin_sync2;
  logic [1:0] pin_prev;
  logic [1:0] pin_evt;
  logic mc_evt;
  logic [FLG_W-1:0] elem_flags [ELEMS];
  logic [ELEMS-1:0] elem_unmasked;
  logic [ELEMS-1:0] elem_quiet_nan;
  logic [ELEMS-1:0] elem_active;
  logic [FLG_W-1:0] simd_set;
  logic simd_unmasked;
  logic next_fault;
  logic [7:0] next_vec;
  logic next_abort;
  logic next_err_valid;

  // ---------------- alignment check ----------------
  assign low_addr = i_mem_addr[3:0];
  assign check_on = i_align_mask_bit & i_proc_flags_ac // RULE2
    & (i_current_priv_level == USER_PRIV) // RULE4
    & ~i_mem_implicit; // RULE5

  always_comb begin
    align_hit = 1'b0;
    gprot_hit = 1'b0;
    case (i_mem_size)
      AMSF_SZ_WORD: align_hit = check_on & |(low_addr & AMASK_WORD); // RULE3
      AMSF_SZ_DWORD: align_hit = check_on & |(low_addr & AMASK_DWORD);
      AMSF_SZ_QWORD: align_hit = check_on & |(low_addr & AMASK_QWORD);
      AMSF_SZ_DQWORD: begin
        // unaligned moves skip the 16-byte demand but keep the 8-byte check
        if (i_mem_unaligned_ok) begin
          align_hit = check_on & |(low_addr & AMASK_QWORD); // RULE7
        end else begin
          gprot_hit = |(low_addr & AMASK_DQWORD);
        end
      end
      AMSF_SZ_FXSTATE: begin
        // which fault a misaligned image takes depends on FXS_USE_ALIGN and on whether alignment checking is on
        if (check_on && FXS_USE_ALIGN) begin
          align_hit = |(low_addr & AMASK_DQWORD); // RULE6
        end else begin
          gprot_hit = |(low_addr & AMASK_DQWORD);
        end
      end
      default: align_hit = 1'b0;
    endcase
  end

  // combinational so the pipeline can squash the access in the same cycle
  assign o_mem_inhibit = i_mem_req & (align_hit | gprot_hit); // RULE9

  // ---------------- machine check ----------------
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pin_sync1 <= 2'h3;
      pin_sync2 <= 2'h3;
      pin_prev <= 2'h3;
    end else begin
      pin_sync1 <= {i_bus_init_err_n, i_mcheck_err_n};
      pin_sync2 <= pin_sync1;
      pin_prev <= pin_sync2;
    end
  end

  // falling edge of each pin is one event, so a held pin does not re-fire
  assign pin_evt = {2{i_mcheck_pin_en}} & ~pin_sync2 & pin_prev; // RULE10
  assign mc_evt = (|pin_evt) | i_int_mcheck;

  always_comb begin
    next_mc_state = mc_state;
    case (mc_state)
      AMSF_MC_RUN: begin
        if (mc_evt) begin
          next_mc_state = i_mcheck_enable ? AMSF_MC_LATCHED : AMSF_MC_SHUT; // RULE12
        end
      end
      AMSF_MC_LATCHED: begin
        if (mc_evt && !i_mcheck_enable) begin
          next_mc_state = AMSF_MC_SHUT;
        end else if (i_mc_status_clr && !mc_evt) begin
          next_mc_state = AMSF_MC_RUN;
        end
      end
      AMSF_MC_SHUT: next_mc_state = AMSF_MC_SHUT;
      default: next_mc_state = AMSF_MC_SHUT;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      mc_state <= AMSF_MC_RUN;
    end else begin
      mc_state <= next_mc_state;
    end
  end

  assign o_shutdown = (mc_state == AMSF_MC_SHUT);

  // error details stay here; the fault itself carries none
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_mc_valid <= 1'b0;
      o_mc_info <= '0;
      o_saved_ptr_valid <= 1'b0;
      o_mc_source <= 3'h0;
    end else if (mc_evt) begin
      o_mc_valid <= 1'b1; // RULE10
      o_mc_info <= i_mc_info; // RULE11
      o_saved_ptr_valid <= i_mc_ptr_assoc; // RULE13
      o_mc_source <= {i_int_mcheck, pin_evt};
    end else if (i_mc_status_clr) begin
      o_mc_valid <= 1'b0;
      o_saved_ptr_valid <= 1'b0;
    end
  end

  // ---------------- simd numeric conditions ----------------
  genvar e;
  generate
    for (e = 0; e < ELEMS; e++) begin : g_elem
      assign elem_active[e] = i_simd_req & (!i_simd_two_elems || e < HALF);
      amsf_elem_prio u_prio (
        .i_cond(i_simd_cond[e*COND_W +: COND_W]),
        .i_mask(o_simd_masks),
        .o_flags(elem_flags[e]),
        .o_unmasked(elem_unmasked[e]),
        .o_quiet_nan_res(elem_quiet_nan[e])
      );
    end
  endgenerate

  // each element reports independently; flags merge across elements
  always_comb begin
    simd_set = '0;
    for (int k = 0; k < ELEMS; k++) begin
      if (elem_active[k]) begin
        simd_set = simd_set | elem_flags[k]; // RULE21
      end
    end
  end

  assign simd_unmasked = |(elem_unmasked & elem_active);

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_simd_flags <= SIMD_FLAG_RST;
    end else begin
      // a new condition wins over a clear in the same cycle
      o_simd_flags <= (o_simd_flags & ~i_simd_flag_clr) | simd_set; // RULE14
    end
  end

  // a mask write only changes masks; it never starts a fault on old flags
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_simd_masks <= SIMD_MASK_RST;
    end else if (i_simd_mask_wr) begin
      o_simd_masks <= i_simd_mask_data; // RULE20
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_simd_default_res <= 1'b0;
      o_simd_quiet_nan_res <= '0;
    end else begin
      o_simd_default_res <= (|simd_set) & ~simd_unmasked; // RULE16
      o_simd_quiet_nan_res <= elem_quiet_nan & elem_active;
    end
  end

  // ---------------- fault selection ----------------
  // machine check outranks the data reference, which outranks simd
  always_comb begin
    next_fault = 1'b0;
    next_vec = VEC_ALIGN;
    next_abort = 1'b0;
    next_err_valid = 1'b0;
    if (mc_evt && i_mcheck_enable && mc_state != AMSF_MC_SHUT) begin
      next_fault = 1'b1;
      next_vec = VEC_MCHECK; // RULE1
      next_abort = 1'b1; // RULE11
    end else if (i_mem_req && align_hit) begin
      next_fault = 1'b1;
      next_vec = VEC_ALIGN;
      next_err_valid = 1'b1; // RULE8
    end else if (i_mem_req && gprot_hit) begin
      next_fault = 1'b1;
      next_vec = VEC_GEN_PROT;
      next_err_valid = 1'b1;
    end else if (i_simd_req && simd_unmasked) begin // RULE19
      next_fault = 1'b1;
      next_vec = i_os_simd_fault_support ? VEC_SIMD : VEC_BAD_OPCODE; // RULE17 RULE18
    end
    if (mc_state == AMSF_MC_SHUT || next_mc_state == AMSF_MC_SHUT) begin
      next_fault = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_fault <= 1'b0;
      o_fault_vec <= VEC_ALIGN;
      o_fault_abort <= 1'b0;
      o_fault_err_valid <= 1'b0;
      o_fault_err_code <= ERR_CODE_ZERO;
      o_fault_ip <= '0;
      o_fault_cs <= '0;
    end else begin
      o_fault <= next_fault;
      o_fault_vec <= next_vec;
      o_fault_abort <= next_abort;
      o_fault_err_valid <= next_err_valid;
      o_fault_err_code <= ERR_CODE_ZERO;
      if (next_fault) begin
        o_fault_ip <= i_instr_pointer; // RULE8
        o_fault_cs <= i_code_seg;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  align_err_zero_a: assert property ( // RULE8
    o_fault && o_fault_vec == VEC_ALIGN |-> o_fault_err_valid && o_fault_err_code == ERR_CODE_ZERO)
    else $error("alignment fault without zero error code");

  align_user_only_a: assert property ( // RULE4
    i_mem_req && i_current_priv_level != USER_PRIV |=> !(o_fault && o_fault_vec == VEC_ALIGN))
    else $error("alignment fault outside user privilege");

  align_implicit_a: assert property ( // RULE5
    i_mem_req && i_mem_implicit |=> !(o_fault && o_fault_vec == VEC_ALIGN))
    else $error("alignment fault on implicit reference");

  align_inhibit_a: assert property ( // RULE9
    o_fault && o_fault_vec == VEC_ALIGN |-> $past(o_mem_inhibit) && $past(i_instr_pointer) == o_fault_ip)
    else $error("alignment fault without squashed access");

  mc_abort_class_a: assert property ( // RULE11
    o_fault && o_fault_vec == VEC_MCHECK |-> o_fault_abort && !o_fault_err_valid && o_mc_valid)
    else $error("machine check not an abort without code");

  mc_pin_fault_a: assert property ( // RULE10
    $fell(i_mcheck_err_n) && i_mcheck_pin_en && i_mcheck_enable && mc_state == AMSF_MC_RUN
      ##1 (i_mcheck_pin_en && i_mcheck_enable && !i_mc_status_clr)[*2]
      |=> o_mc_valid && o_fault && o_fault_vec == VEC_MCHECK)
    else $error("bus error pin did not raise machine check");

  mc_shutdown_a: assert property ( // RULE12
    mc_evt && !i_mcheck_enable |=> o_shutdown && !o_fault ##1 o_shutdown)
    else $error("disabled machine check did not shut down");

  simd_os_route_a: assert property ( // RULE18
    o_fault && (o_fault_vec == VEC_SIMD || o_fault_vec == VEC_BAD_OPCODE)
      |-> $past(i_simd_req) && (o_fault_vec == VEC_SIMD) == $past(i_os_simd_fault_support))
    else $error("simd fault routed to wrong vector");

  simd_no_late_a: assert property ( // RULE20
    !i_simd_req |=> !(o_fault && o_fault_vec == VEC_SIMD))
    else $error("simd fault without a simd request");

  simd_flags_kept_a: assert property ( // RULE21
    i_simd_req |=> (o_simd_flags & $past(simd_set)) == $past(simd_set))
    else $error("element condition lost from flags");

endmodule : amsf_fault_unit

// ===== test/amsf_bus_agent.sv
// amsf_bus_agent: external bus agent that reports bus errors on the two error pins
module amsf_bus_agent (
  // control from the bench
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_sel_init,
  input wire logic [3:0] i_delay,
  // error pins, pulled up while released
  output logic o_bus_init_err_n,
  output logic o_mcheck_err_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // one process owns both pins; held low for several cycles, so the design must fire once per assertion
  initial begin
    o_bus_init_err_n = 1'b1;
    o_mcheck_err_n = 1'b1;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        repeat (i_delay) @(posedge i_clk);
        if (i_sel_init) begin
          o_bus_init_err_n <= 1'b0;
        end else begin
          o_mcheck_err_n <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        o_bus_init_err_n <= 1'b1;
        o_mcheck_err_n <= 1'b1;
      end
    end
  end
endmodule : amsf_bus_agent

// ===== test/amsf_fault_unit_tb_top.sv
// amsf_fault_unit_tb_top: self-checking bench for the alignment, machine-check and simd fault unit
module amsf_fault_unit_tb_top import amsf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_core_clk, i_nrst, i_align_mask_bit, i_proc_flags_ac, i_mcheck_enable, i_os_simd_fault_support;
  logic [1:0] i_current_priv_level;
  logic [31:0] i_instr_pointer, i_mem_addr, i_mc_info, i_simd_cond, o_mc_info, o_fault_err_code, o_fault_ip;
  logic [15:0] i_code_seg, o_fault_cs;
  amsf_size_t i_mem_size;
  logic i_mem_req, i_mem_implicit, i_mem_unaligned_ok, o_mem_inhibit, i_bus_init_err_n, i_mcheck_err_n;
  logic i_mcheck_pin_en, i_int_mcheck, i_mc_ptr_assoc, i_mc_status_clr, o_mc_valid, o_saved_ptr_valid, o_shutdown;
  logic [2:0] o_mc_source;
  logic i_simd_req, i_simd_two_elems, i_simd_mask_wr, o_simd_default_res, o_fault, o_fault_abort, o_fault_err_valid;
  logic [5:0] i_simd_mask_data, i_simd_flag_clr, o_simd_flags, o_simd_masks;
  logic [3:0] o_simd_quiet_nan_res, ag_dly;
  logic [7:0] o_fault_vec;
  logic ag_go, ag_sel;
  int n_errors, tests_run;

  amsf_fault_unit dut (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_align_mask_bit(i_align_mask_bit),
    .i_proc_flags_ac(i_proc_flags_ac), .i_current_priv_level(i_current_priv_level),
    .i_mcheck_enable(i_mcheck_enable), .i_os_simd_fault_support(i_os_simd_fault_support),
    .i_instr_pointer(i_instr_pointer), .i_code_seg(i_code_seg), .i_mem_req(i_mem_req),
    .i_mem_addr(i_mem_addr), .i_mem_size(i_mem_size), .i_mem_implicit(i_mem_implicit),
    .i_mem_unaligned_ok(i_mem_unaligned_ok), .o_mem_inhibit(o_mem_inhibit),
    .i_bus_init_err_n(i_bus_init_err_n), .i_mcheck_err_n(i_mcheck_err_n), .i_mcheck_pin_en(i_mcheck_pin_en),
    .i_int_mcheck(i_int_mcheck), .i_mc_info(i_mc_info), .i_mc_ptr_assoc(i_mc_ptr_assoc),
    .i_mc_status_clr(i_mc_status_clr), .o_mc_valid(o_mc_valid), .o_mc_info(o_mc_info),
    .o_saved_ptr_valid(o_saved_ptr_valid), .o_mc_source(o_mc_source), .o_shutdown(o_shutdown),
    .i_simd_req(i_simd_req), .i_simd_two_elems(i_simd_two_elems), .i_simd_cond(i_simd_cond),
    .i_simd_mask_wr(i_simd_mask_wr), .i_simd_mask_data(i_simd_mask_data), .i_simd_flag_clr(i_simd_flag_clr),
    .o_simd_flags(o_simd_flags), .o_simd_masks(o_simd_masks), .o_simd_default_res(o_simd_default_res),
    .o_simd_quiet_nan_res(o_simd_quiet_nan_res), .o_fault(o_fault), .o_fault_vec(o_fault_vec),
    .o_fault_abort(o_fault_abort), .o_fault_err_valid(o_fault_err_valid),
    .o_fault_err_code(o_fault_err_code), .o_fault_ip(o_fault_ip), .o_fault_cs(o_fault_cs)
  );

  amsf_bus_agent agent (
    .i_clk(i_core_clk), .i_go(ag_go), .i_sel_init(ag_sel), .i_delay(ag_dly),
    .o_bus_init_err_n(i_bus_init_err_n), .o_mcheck_err_n(i_mcheck_err_n)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one data reference; inhibit is combinational, the fault lands one edge later
  task automatic mem(input amsf_size_t sz, input logic [31:0] a, input logic ef, input logic [7:0] ev);
    @(negedge i_core_clk);
    i_mem_req = 1'b1;
    i_mem_size = sz;
    i_mem_addr = a;
    i_instr_pointer = a + 32'h0000_0100;
    #1 chk("inhibit", ef, o_mem_inhibit);
    @(negedge i_core_clk);
    i_mem_req = 1'b0;
    chk("mem fault", ef, o_fault);
    if (ef) begin
      chk("mem vector", ev, o_fault_vec);
      chk("err valid", 1'b1, o_fault_err_valid);
      chk("err code", 32'h0, o_fault_err_code);
      chk("fault ip", a + 32'h0000_0100, o_fault_ip);
      chk("fault cs", i_code_seg, o_fault_cs);
    end
  endtask : mem

  // flags are cleared first so each request shows only its own report
  task automatic simd(input logic [31:0] c, input logic [5:0] ef, input logic efl, input logic [7:0] ev,
                      input logic ed, input logic [3:0] eq);
    @(negedge i_core_clk);
    i_simd_flag_clr = 6'h3f;
    @(negedge i_core_clk);
    i_simd_flag_clr = 6'h00;
    i_simd_req = 1'b1;
    i_simd_cond = c;
    @(negedge i_core_clk);
    i_simd_req = 1'b0;
    chk("flags", ef, o_simd_flags);
    chk("simd fault", efl, o_fault);
    if (efl) chk("simd vector", ev, o_fault_vec);
    chk("default result", ed, o_simd_default_res);
    chk("quiet result", eq, o_simd_quiet_nan_res);
  endtask : simd

  task automatic setm(input logic [5:0] m);
    @(negedge i_core_clk);
    i_simd_mask_wr = 1'b1;
    i_simd_mask_data = m;
    @(negedge i_core_clk);
    i_simd_mask_wr = 1'b0;
    chk("masks", m, o_simd_masks);
    chk("mask write fault", 1'b0, o_fault);
    @(negedge i_core_clk);
    chk("mask write fault", 1'b0, o_fault);
  endtask : setm

  task automatic mcclr;
    @(negedge i_core_clk);
    i_mc_status_clr = 1'b1;
    @(negedge i_core_clk);
    i_mc_status_clr = 1'b0;
    chk("mc cleared", 1'b0, o_mc_valid);
  endtask : mcclr

  task automatic mcint(input logic [31:0] info, input logic pa);
    @(negedge i_core_clk);
    i_int_mcheck = 1'b1;
    i_mc_info = info;
    i_mc_ptr_assoc = pa;
    @(negedge i_core_clk);
    i_int_mcheck = 1'b0;
    chk("mc fault", 1'b1, o_fault);
    chk("mc vector", VEC_MCHECK, o_fault_vec);
    chk("abort", 1'b1, o_fault_abort);
    chk("mc err valid", 1'b0, o_fault_err_valid);
    chk("mc valid", 1'b1, o_mc_valid);
    chk("mc info", info, o_mc_info);
    chk("ptr valid", pa, o_saved_ptr_valid);
    chk("mc source", 3'b100, o_mc_source);
    mcclr();
  endtask : mcint

  task automatic pin(input logic sel, input logic en, input int nf, input logic [2:0] src);
    int cnt;
    cnt = 0;
    @(negedge i_core_clk);
    i_mcheck_pin_en = en;
    ag_go = 1'b1;
    ag_sel = sel;
    @(negedge i_core_clk);
    ag_go = 1'b0;
    repeat (14) begin
      @(negedge i_core_clk);
      if (o_fault === 1'b1) cnt++;
    end
    chk("pin faults", nf, cnt);
    chk("pin mc valid", nf, o_mc_valid);
    if (nf != 0) chk("pin source", src, o_mc_source);
    mcclr();
  endtask : pin

  initial begin
    {i_nrst, i_mem_req, i_mem_implicit, i_mem_unaligned_ok, i_int_mcheck, i_mc_ptr_assoc} = '0;
    {i_mc_status_clr, i_simd_req, i_simd_two_elems, i_simd_mask_wr, i_mcheck_pin_en, ag_go, ag_sel} = '0;
    {i_instr_pointer, i_mem_addr, i_mc_info, i_simd_cond, i_simd_mask_data, i_simd_flag_clr, ag_dly} = '0;
    {i_align_mask_bit, i_proc_flags_ac, i_mcheck_enable, i_os_simd_fault_support} = 4'hf;
    i_current_priv_level = USER_PRIV;
    i_mem_size = AMSF_SZ_BYTE;
    i_code_seg = 16'h0023;
    n_errors = 0;
    tests_run = 0;
    repeat (6) @(negedge i_core_clk);
    i_nrst = 1'b1;
    chk("reset masks", SIMD_MASK_RST, o_simd_masks);
    chk("reset flags", SIMD_FLAG_RST, o_simd_flags);
    chk("reset shutdown", 1'b0, o_shutdown);
    $display("test reset done");
    mem(AMSF_SZ_WORD, 32'h1, 1'b1, VEC_ALIGN);
    mem(AMSF_SZ_WORD, 32'h2, 1'b0, 8'h00);
    mem(AMSF_SZ_DWORD, 32'h2, 1'b1, VEC_ALIGN);
    mem(AMSF_SZ_DWORD, 32'h4, 1'b0, 8'h00);
    mem(AMSF_SZ_QWORD, 32'h4, 1'b1, VEC_ALIGN);
    mem(AMSF_SZ_QWORD, 32'h8, 1'b0, 8'h00);
    mem(AMSF_SZ_BYTE, 32'h3, 1'b0, 8'h00);
    $display("test alignment sizes done");
    i_current_priv_level = 2'h2;
    mem(AMSF_SZ_WORD, 32'h1, 1'b0, 8'h00);
    i_current_priv_level = USER_PRIV;
    i_align_mask_bit = 1'b0;
    mem(AMSF_SZ_WORD, 32'h1, 1'b0, 8'h00);
    i_align_mask_bit = 1'b1;
    i_proc_flags_ac = 1'b0;
    mem(AMSF_SZ_WORD, 32'h1, 1'b0, 8'h00);
    i_proc_flags_ac = 1'b1;
    i_mem_implicit = 1'b1;
    mem(AMSF_SZ_WORD, 32'h1, 1'b0, 8'h00);
    i_mem_implicit = 1'b0;
    $display("test alignment enables done");
    mem(AMSF_SZ_FXSTATE, 32'h8, 1'b1, VEC_ALIGN);
    i_align_mask_bit = 1'b0;
    mem(AMSF_SZ_FXSTATE, 32'h8, 1'b1, VEC_GEN_PROT);
    mem(AMSF_SZ_DQWORD, 32'h4, 1'b1, VEC_GEN_PROT);
    i_mem_unaligned_ok = 1'b1;
    mem(AMSF_SZ_DQWORD, 32'h8, 1'b0, 8'h00);
    i_align_mask_bit = 1'b1;
    mem(AMSF_SZ_DQWORD, 32'h8, 1'b0, 8'h00);
    mem(AMSF_SZ_DQWORD, 32'h4, 1'b1, VEC_ALIGN);
    i_mem_unaligned_ok = 1'b0;
    $display("test wide operands done");
    simd(32'h2010_0804, 6'h0f, 1'b0, 8'h00, 1'b1, 4'h0);
    simd(32'h0000_8040, 6'h30, 1'b0, 8'h00, 1'b1, 4'h0);
    // a masked signalling nan lets the divide-by-zero below it report as well
    simd(32'h0000_0009, 6'h03, 1'b0, 8'h00, 1'b1, 4'h0);
    simd(32'h0000_000a, 6'h00, 1'b0, 8'h00, 1'b0, 4'h1);
    simd(32'h0000_00a0, 6'h28, 1'b0, 8'h00, 1'b1, 4'h0);
    i_simd_two_elems = 1'b1;
    simd(32'h0008_0004, 6'h01, 1'b0, 8'h00, 1'b1, 4'h0);
    i_simd_two_elems = 1'b0;
    $display("test simd priority done");
    simd(32'h0000_0008, 6'h02, 1'b0, 8'h00, 1'b1, 4'h0);
    setm(6'h3d);
    chk("flag kept", 6'h02, o_simd_flags);
    simd(32'h0000_00a8, 6'h02, 1'b1, VEC_SIMD, 1'b0, 4'h0);
    i_os_simd_fault_support = 1'b0;
    simd(32'h0000_0008, 6'h02, 1'b1, VEC_BAD_OPCODE, 1'b0, 4'h0);
    i_os_simd_fault_support = 1'b1;
    simd(32'h0000_0004, 6'h01, 1'b0, 8'h00, 1'b1, 4'h0);
    setm(6'h3f);
    $display("test simd faults done");
    mcint(32'h1234_5678, 1'b1);
    mcint(32'h0bad_0001, 1'b0);
    pin(1'b0, 1'b1, 1, 3'b001);
    ag_dly = 4'h3;
    pin(1'b1, 1'b1, 1, 3'b010);
    pin(1'b0, 1'b0, 0, 3'b000);
    $display("test machine check done");
    i_mcheck_enable = 1'b0;
    @(negedge i_core_clk);
    i_int_mcheck = 1'b1;
    @(negedge i_core_clk);
    i_int_mcheck = 1'b0;
    chk("shutdown", 1'b1, o_shutdown);
    chk("no mc fault", 1'b0, o_fault);
    @(negedge i_core_clk);
    chk("shutdown held", 1'b1, o_shutdown);
    $display("test shutdown done");
    stop_test();
  end

  // whole run is under 150 cycles; this leaves a wide margin
  initial begin
    repeat (3000) @(posedge i_core_clk);
    n_errors++;
    $display("watchdog expired");
    stop_test();
  end
endmodule : amsf_fault_unit_tb_top
